//--- indirect_defs.svh
// Constants for the indirect register and memory access block
`ifndef INDIRECT_DEFS_SVH
`define INDIRECT_DEFS_SVH

`define IRM_REG_ACC1_HIGH 4'h0
`define IRM_REG_ACC1_LOW 4'h1
`define IRM_REG_ACC2_LOW 4'h3
`define IRM_REG_STACK 4'h5
`define IRM_REG_BASE 4'h6
`define IRM_REG_COUNT 4'h8
`define IRM_REG_ACC3_HIGH 4'h9
`define IRM_REG_ACC4_LOW 4'hC
`define IRM_REG_NEXT_OP 4'hF
`define IRM_BANK_SHIFT 4'h5

`define IRM_BYTE_LOW_FIRST 16'hE400
`define IRM_BYTE_LOW_LAST 16'hE7FF
`define IRM_BYTE_HIGH_FIRST 16'hEE00
`define IRM_PAGE_FIRST 16'hF400
`define IRM_PAGE_LAST 16'hFBFF
`define IRM_BYTE_FILL 8'hFF

`define IRM_BASE_RESET 16'h0000
`define IRM_COUNT_RESET 16'h0000
`define IRM_WORD_RESET 16'h0000

`endif

//--- indirect_pkg.sv
// Types shared by the indirect register and memory access block
`default_nettype none
package indirect_pkg;
	typedef struct packed {
		logic store;
		logic [3:0] regno;
	} indirect_cmd_t;

	typedef struct packed {
		logic we;
		logic [19:0] addr;
		logic [15:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic [15:0] base;
		logic [15:0] length;
	} block_info_t;
endpackage
`default_nettype wire

//--- acc_bank.sv
// Eight-word accumulator store with registered read data
`default_nettype none
module acc_bank #(
	parameter int DEPTH = 8,
	parameter int WIDTH = 16
) (
	input wire logic sys_clk, // System clock
	input wire logic [$clog2(DEPTH)-1:0] raddr, // Read index
	output logic [WIDTH-1:0] rdata, // Read data, one cycle late
	input wire logic we, // Write strobe
	input wire logic [$clog2(DEPTH)-1:0] waddr, // Write index
	input wire logic [WIDTH-1:0] wdata // Write data
);
	logic [WIDTH-1:0] mem [DEPTH];

	if (DEPTH < 2 || WIDTH < 1)
	begin : g_bad_geometry
		$error("acc_bank: unsupported geometry");
	end

	always_ff @(posedge sys_clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end
endmodule
`default_nettype wire

//--- area_decode.sv
// Classifies a memory address as byte-wide or page area
`include "indirect_defs.svh"
`default_nettype none
module area_decode (
	input wire logic [15:0] addr, // Low word of the address
	output logic byte_wide, // Area is eight bits wide
	output logic page_area // Multiprocessor page area
);
	wire logic in_low_bytes = addr >= `IRM_BYTE_LOW_FIRST && addr <= `IRM_BYTE_LOW_LAST;
	wire logic in_high_bytes = addr >= `IRM_BYTE_HIGH_FIRST;

	assign byte_wide = in_low_bytes || in_high_bytes;
	// Flag only; software keeps indirect access out of this range
	assign page_area = addr >= `IRM_PAGE_FIRST && addr <= `IRM_PAGE_LAST;
endmodule
`default_nettype wire

//--- indirect_access.sv
// Register file and execution of indirect register load and store
`include "indirect_defs.svh"
`default_nettype none
module indirect_access (
	input wire logic sys_clk, // 20 MHz clock
	input wire logic sys_rst, // Synchronous reset, active high
	input wire logic cmd_valid, // Indirect operation request
	input wire indirect_pkg::indirect_cmd_t cmd, // Direction and register number
	output logic cmd_busy, // Operation in progress
	output logic cmd_done, // Operation finished, one cycle
	input wire logic acc_wr_valid, // CPU writes an accumulator word
	input wire logic [3:0] acc_wr_regno, // Register number of that word
	input wire logic [15:0] acc_wr_data, // Data for that word
	input wire logic [3:0] acc_rd_regno, // Accumulator word to read back
	output logic [15:0] acc_rd_data, // Read back data, one cycle late
	input wire logic op_pointer_load, // Sequencer advances
	input wire logic [15:0] op_pointer_in, // Address of next operation
	output logic [15:0] next_operation_pointer, // Register 15
	input wire logic stack_load, // CPU sets the block stack pointer
	input wire logic [15:0] stack_in, // New block stack pointer
	output logic [15:0] stack_pointer, // Register 5
	input wire logic entry_call, // Cyclic or alternate entry block call
	input wire logic open_valid, // Data block opened
	input wire indirect_pkg::block_info_t open_info, // Its first word and length
	input wire logic restore_valid, // Return to higher level block
	input wire indirect_pkg::block_info_t restore_info, // Values to restore
	input wire logic shift_valid, // Block shift service request
	input wire logic [15:0] shift_count, // Words to shift by
	output logic shift_fault, // Shift refused, count too large
	input wire logic dw_valid, // Data word access request
	input wire logic [7:0] dw_offset, // Data word number
	output logic [15:0] dw_addr, // Absolute address of that word
	output logic dw_fault, // Offset beyond word count
	output logic [15:0] block_base_pointer, // Register 6
	output logic [15:0] block_word_count, // Register 8
	output logic mem_req, // Memory request, held until ack
	output indirect_pkg::mem_req_t mem, // Memory request fields
	input wire logic mem_ack, // Memory finished access
	input wire logic [15:0] mem_rdata // Memory read data at ack
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ADDR = 4'b0010,
		ST_SRC = 4'b0100,
		ST_MEM = 4'b1000
	} state_t;

	state_t state;
	state_t next_state;
	logic store_op;
	logic [3:0] op_regno;
	logic [15:0] op_addr;
	logic op_byte;
	logic [15:0] bank_rdata;

	// Register number classes
	function automatic logic is_acc(input logic [3:0] r);
		is_acc = r <= `IRM_REG_ACC2_LOW || (r >= `IRM_REG_ACC3_HIGH && r <= `IRM_REG_ACC4_LOW);
	endfunction

	function automatic logic [2:0] bank_index(input logic [3:0] r);
		logic [3:0] shifted;
		shifted = r - `IRM_BANK_SHIFT;
		bank_index = (r <= `IRM_REG_ACC2_LOW) ? r[2:0] : shifted[2:0];
	endfunction

	function automatic logic is_special(input logic [3:0] r);
		is_special = r == `IRM_REG_STACK || r == `IRM_REG_BASE || r == `IRM_REG_COUNT;
	endfunction

	wire logic accept = state == ST_IDLE && cmd_valid;
	wire logic cmd_noop = !is_acc(cmd.regno) && !is_special(cmd.regno);
	wire logic accept_mem = accept && !cmd_noop;
	wire logic ack_now = state == ST_MEM && mem_ack;
	wire logic load_wb = ack_now && !store_op;

	// Bank read: address word first, then the source word, else the CPU read port
	wire logic [2:0] bank_raddr = accept_mem ? bank_index(`IRM_REG_ACC1_LOW) :
		(state == ST_ADDR) ? bank_index(op_regno) : bank_index(acc_rd_regno);

	// Byte areas pad the high byte with ones; word areas pass all 16 bits
	wire logic [15:0] load_value = op_byte ? {`IRM_BYTE_FILL, mem_rdata[7:0]} :
		mem_rdata;

	wire logic bank_we_fsm = load_wb && is_acc(op_regno);
	wire logic bank_we_cpu = acc_wr_valid && state == ST_IDLE && is_acc(acc_wr_regno);
	wire logic bank_we = bank_we_fsm || bank_we_cpu;
	wire logic [2:0] bank_waddr = bank_we_fsm ? bank_index(op_regno) : bank_index(acc_wr_regno);
	wire logic [15:0] bank_wdata = bank_we_fsm ? load_value : acc_wr_data;

	wire logic addr_byte;
	wire logic addr_page;
	wire logic [15:0] captured_addr = bank_rdata;

	// Source of a store: accumulator word or one of the special registers
	wire logic [15:0] special_value = (op_regno == `IRM_REG_STACK) ? stack_pointer :
		(op_regno == `IRM_REG_BASE) ? block_base_pointer : block_word_count;
	wire logic [15:0] store_value = is_acc(op_regno) ? bank_rdata : special_value;
	wire logic [15:0] store_data = op_byte ? {8'h00, store_value[7:0]} :
		store_value;

	// Base pointer and word count updates, highest priority first
	wire logic shift_ok = shift_valid && shift_count < block_word_count;
	wire logic load_base = load_wb && op_regno == `IRM_REG_BASE;
	wire logic load_count = load_wb && op_regno == `IRM_REG_COUNT;
	wire logic [15:0] next_base = entry_call ? `IRM_BASE_RESET :
		open_valid ? open_info.base :
		restore_valid ? restore_info.base :
		shift_ok ? block_base_pointer + shift_count :
		load_base ? load_value : block_base_pointer;
	wire logic [15:0] next_count = entry_call ? `IRM_COUNT_RESET :
		open_valid ? open_info.length :
		restore_valid ? restore_info.length :
		shift_ok ? block_word_count - shift_count :
		load_count ? load_value : block_word_count;
	wire logic block_events = entry_call || open_valid || restore_valid || shift_valid;

	area_decode u_area (
		.addr(captured_addr),
		.byte_wide(addr_byte),
		.page_area(addr_page)
	);

	acc_bank #(
		.DEPTH(8),
		.WIDTH(16)
	) u_bank (
		.sys_clk(sys_clk),
		.raddr(bank_raddr),
		.rdata(bank_rdata),
		.we(bank_we),
		.waddr(bank_waddr),
		.wdata(bank_wdata)
	);

	assign acc_rd_data = bank_rdata;

	always_comb
	begin
		next_state = state;
		case (state)
			ST_IDLE: next_state = accept_mem ? ST_ADDR : ST_IDLE;
			ST_ADDR: next_state = ST_SRC;
			ST_SRC: next_state = ST_MEM;
			ST_MEM: next_state = mem_ack ? ST_IDLE : ST_MEM;
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
			state <= ST_IDLE;
		else
			state <= next_state;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			store_op <= 1'b0;
			op_regno <= 4'h0;
			op_addr <= `IRM_WORD_RESET;
			op_byte <= 1'b0;
		end
		else if (accept)
		begin
			store_op <= cmd.store;
			op_regno <= cmd.regno;
		end
		else if (state == ST_ADDR)
		begin
			op_addr <= captured_addr;
			op_byte <= addr_byte;
		end
	end

	// Memory request rises at the end of the source cycle and stays up until the ack
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			mem_req <= 1'b0;
			mem <= '0;
		end
		else if (state == ST_SRC)
		begin
			mem_req <= 1'b1;
			mem.we <= store_op;
			mem.addr <= {4'h0, op_addr};
			mem.wdata <= store_op ? store_data : `IRM_WORD_RESET;
		end
		else if (ack_now)
			mem_req <= 1'b0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			cmd_busy <= 1'b0;
			cmd_done <= 1'b0;
		end
		else
		begin
			cmd_busy <= next_state != ST_IDLE;
			cmd_done <= (accept && cmd_noop) || ack_now;
		end
	end

	// Jumps and level insertions have no input here, so nothing disturbs these
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			block_base_pointer <= `IRM_BASE_RESET;
			block_word_count <= `IRM_COUNT_RESET;
			shift_fault <= 1'b0;
		end
		else
		begin
			block_base_pointer <= next_base;
			block_word_count <= next_count;
			shift_fault <= shift_valid && !shift_ok;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			stack_pointer <= `IRM_WORD_RESET;
			next_operation_pointer <= `IRM_WORD_RESET;
		end
		else
		begin
			if (load_wb && op_regno == `IRM_REG_STACK)
				stack_pointer <= load_value;
			else if (stack_load)
				stack_pointer <= stack_in;
			if (op_pointer_load)
				next_operation_pointer <= op_pointer_in;
		end
	end

	// Eight-bit offset keeps ordinary data word access within word 255
	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			dw_addr <= `IRM_WORD_RESET;
			dw_fault <= 1'b0;
		end
		else if (dw_valid)
		begin
			dw_addr <= block_base_pointer + {8'h00, dw_offset};
			dw_fault <= {8'h00, dw_offset} >= block_word_count;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	sequence s_accept_noop;
		accept && cmd_noop;
	endsequence

	sequence s_accept_mem;
		accept_mem;
	endsequence

	chk_noop_no_access: assert property (s_accept_noop |=> cmd_done && !mem_req && !cmd_busy)
		else $error("no-operation register touched memory");

	chk_request_timing: assert property (s_accept_mem |-> ##3 mem_req)
		else $error("memory request not issued three cycles after accept");

	chk_reg12_is_acc: assert property (accept && cmd.regno == `IRM_REG_ACC4_LOW |-> !cmd_noop)
		else $error("fourth accumulator low treated as no-operation");

	chk_byte_store_low: assert property (mem_req && mem.we && op_byte |-> mem.wdata[15:8] == 8'h00)
		else $error("byte store carries a high byte");

	chk_page_kept_out: assert property (state == ST_ADDR |-> !addr_page)
		else $error("indirect access aimed at the page area");

	chk_entry_base_clear: assert property (entry_call |=> block_base_pointer == 16'h0000)
		else $error("base pointer not cleared at entry call");

	chk_entry_count_clear: assert property (entry_call |=> block_word_count == 16'h0000)
		else $error("word count not cleared at entry call");

	chk_open_loads_base: assert property (open_valid && !entry_call |=>
		block_base_pointer == $past(open_info.base))
		else $error("open did not load base pointer");

	chk_open_loads_count: assert property (open_valid && !entry_call |=>
		block_word_count == $past(open_info.length))
		else $error("open did not load word count");

	chk_base_load_count: assert property (load_base && !block_events |=>
		$stable(block_word_count) && block_base_pointer == $past(load_value))
		else $error("indirect base load disturbed word count");

	chk_shift_balance: assert property (shift_ok && !entry_call && !open_valid && !restore_valid
		|=> block_base_pointer + block_word_count ==
		$past(block_base_pointer) + $past(block_word_count))
		else $error("block shift did not balance base and count");

	chk_quiet_keeps: assert property (!block_events && !load_wb |=>
		$stable(block_base_pointer) && $stable(block_word_count))
		else $error("data block registers changed without cause");
endmodule
`default_nettype wire

//--- mem_model.sv
// Behavioural local memory answering indirect access requests
`default_nettype none
module mem_model (
	input wire logic sys_clk, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic [3:0] wait_cycles, // Cycles before the answer
	input wire logic mem_req, // Access request
	input wire indirect_pkg::mem_req_t mem, // Access fields
	output logic mem_ack, // Access finished, one cycle
	output logic [15:0] mem_rdata // Read data at ack
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [15:0] cells [0:65535];
	logic [19:0] last_addr;
	logic [15:0] last_wdata;
	logic last_we;
	logic [3:0] cnt;
	logic byte_area;
	logic [15:0] word;
	assign byte_area = (mem.addr[15:0] >= 16'hE400 && mem.addr[15:0] <= 16'hE7FF)
		|| mem.addr[15:0] >= 16'hEE00;
	assign word = cells[mem.addr[15:0]];
	// Read data toggles outside the ack cycle so a stale value never matches
	always @(posedge sys_clk)
	begin
		mem_ack <= 1'b0;
		mem_rdata <= ~mem_rdata;
		if (sys_rst)
		begin
			cnt <= 4'h0;
			mem_rdata <= 16'h5A5A;
		end
		else if (!mem_req || mem_ack)
			cnt <= 4'h0;
		else if (cnt < wait_cycles)
			cnt <= cnt + 4'h1;
		else
		begin
			mem_ack <= 1'b1;
			last_addr <= mem.addr;
			last_we <= mem.we;
			last_wdata <= mem.wdata;
			if (mem.we)
				cells[mem.addr[15:0]] <= mem.wdata;
			else if (byte_area)
				mem_rdata <= {~word[7:0], word[7:0]}; // Byte cells leave the high byte undefined
			else
				mem_rdata <= word;
		end
	end
endmodule
`default_nettype wire

//--- tb.sv
// Self-checking testbench for the indirect access block
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, sys_rst = 1, cmd_valid = 0, cmd_busy, cmd_done, acc_wr_valid = 0;
	indirect_pkg::indirect_cmd_t cmd = '0;
	logic [3:0] acc_wr_regno = 0, acc_rd_regno = 0, wait_cycles = 0;
	logic [15:0] acc_wr_data = 0, acc_rd_data, op_pointer_in = 0, next_operation_pointer;
	logic op_pointer_load = 0, stack_load = 0, entry_call = 0, open_valid = 0;
	logic restore_valid = 0, shift_valid = 0, shift_fault, dw_valid = 0, dw_fault;
	logic [15:0] stack_in = 0, stack_pointer, shift_count = 0, dw_addr;
	logic [15:0] block_base_pointer, block_word_count, mem_rdata;
	indirect_pkg::block_info_t open_info = '0, restore_info = '0;
	logic [7:0] dw_offset = 0;
	logic mem_req, mem_ack;
	indirect_pkg::mem_req_t mem;
	int err_total = 0, n_compared = 0, cyc;
	logic used, busy_gap;
	indirect_access u_indirect_access (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.cmd_valid(cmd_valid), .cmd(cmd), .cmd_busy(cmd_busy), .cmd_done(cmd_done),
		.acc_wr_valid(acc_wr_valid), .acc_wr_regno(acc_wr_regno), .acc_wr_data(acc_wr_data),
		.acc_rd_regno(acc_rd_regno), .acc_rd_data(acc_rd_data),
		.op_pointer_load(op_pointer_load), .op_pointer_in(op_pointer_in),
		.next_operation_pointer(next_operation_pointer), .stack_load(stack_load),
		.stack_in(stack_in), .stack_pointer(stack_pointer), .entry_call(entry_call),
		.open_valid(open_valid), .open_info(open_info), .restore_valid(restore_valid),
		.restore_info(restore_info), .shift_valid(shift_valid), .shift_count(shift_count),
		.shift_fault(shift_fault), .dw_valid(dw_valid), .dw_offset(dw_offset),
		.dw_addr(dw_addr), .dw_fault(dw_fault), .block_base_pointer(block_base_pointer),
		.block_word_count(block_word_count), .mem_req(mem_req), .mem(mem),
		.mem_ack(mem_ack), .mem_rdata(mem_rdata));
	mem_model u_mem_model (.sys_clk(sys_clk), .sys_rst(sys_rst), .wait_cycles(wait_cycles),
		.mem_req(mem_req), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
	initial
	begin
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic close_out;
		if (err_total == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string msg);
		n_compared++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: %s got %h", $time, msg, got);
			err_total++;
		end
	endtask
	task automatic acc_wr(input logic [3:0] r, input logic [15:0] d);
		acc_wr_valid = 1;
		acc_wr_regno = r;
		acc_wr_data = d;
		@(negedge sys_clk);
		acc_wr_valid = 0;
		@(negedge sys_clk);
	endtask
	task automatic acc_rd(input logic [3:0] r, input logic [15:0] exp, input string msg);
		acc_rd_regno = r;
		@(negedge sys_clk);
		chk(acc_rd_data, exp, msg);
	endtask
	// Issues one indirect operation and waits for its completion pulse
	task automatic run_op(input logic st, input logic [3:0] r);
		cmd_valid = 1;
		cmd = {st, r};
		used = 0;
		busy_gap = 0;
		@(negedge sys_clk);
		cmd_valid = 0;
		cyc = 1;
		while (cmd_done !== 1'b1 && cyc < 40)
		begin
			if (mem_req === 1'b1)
				used = 1;
			if (cmd_busy !== 1'b1)
				busy_gap = 1;
			@(negedge sys_clk);
			cyc++;
		end
		chk({cmd_done, cmd_busy, busy_gap}, 3'h4, "done or busy");
		@(negedge sys_clk);
	endtask
	task automatic t_acc_map;
		logic [3:0] regs [8] = '{0, 1, 2, 3, 9, 10, 11, 12};
		foreach (regs[i]) acc_wr(regs[i], 16'hA100 + 16'(i));
		foreach (regs[i]) acc_rd(regs[i], 16'hA100 + 16'(i), "acc map");
	endtask
	task automatic t_word;
		acc_wr(1, 16'h1000);
		acc_wr(3, 16'hA55A);
		run_op(1, 3);
		chk({u_mem_model.last_we, u_mem_model.last_addr}, 21'h101000, "store addr");
		chk(u_mem_model.last_wdata, 16'hA55A, "store data");
		wait_cycles = 5;
		u_mem_model.cells[16'h1000] = 16'h3C96;
		run_op(0, 12);
		acc_rd(12, 16'h3C96, "load slow");
		wait_cycles = 0;
	endtask
	task automatic t_bytes;
		// Page area F400-FBFF stays out of this table
		logic [15:0] adr [7] = '{16'hE3FF, 16'hE400, 16'hE7FF, 16'hE800, 16'hEDFF, 16'hEE00,
			16'hFFFF};
		logic bw [7] = '{0, 1, 1, 0, 0, 1, 1};
		foreach (adr[i])
		begin
			acc_wr(1, adr[i]);
			acc_wr(10, 16'h12C3);
			run_op(1, 10);
			chk(u_mem_model.last_wdata, bw[i] ? 16'h00C3 : 16'h12C3, "byte store");
			u_mem_model.cells[adr[i]] = 16'h7E5B;
			run_op(0, 11);
			acc_rd(11, bw[i] ? 16'hFF5B : 16'h7E5B, "byte load");
		end
	endtask
	task automatic t_noop;
		logic [3:0] nr [5] = '{4, 7, 13, 14, 15};
		acc_wr(3, 16'h0F0F);
		foreach (nr[i])
		begin
			run_op(i % 2, nr[i]);
			chk({used, 4'(cyc)}, {1'b0, 4'h1}, "noop");
		end
		acc_rd(3, 16'h0F0F, "noop changed reg");
	endtask
	task automatic t_acc1;
		acc_wr(1, 16'h2000);
		u_mem_model.cells[16'h2000] = 16'h3000;
		run_op(0, 1);
		acc_rd(1, 16'h3000, "acc1 load");
		run_op(1, 3);
		chk(u_mem_model.last_addr, 20'h03000, "new addr");
	endtask
	task automatic t_block;
		open_info = {16'h4152, 16'h0008};
		open_valid = 1;
		@(negedge sys_clk);
		open_valid = 0;
		chk({block_base_pointer, block_word_count}, 32'h41520008, "open");
		repeat (3) @(negedge sys_clk);
		chk({block_base_pointer, block_word_count}, 32'h41520008, "hold");
		dw_valid = 1;
		dw_offset = 7;
		@(negedge sys_clk);
		chk({dw_fault, dw_addr}, 17'h04159, "dw 7");
		dw_offset = 8;
		@(negedge sys_clk);
		dw_valid = 0;
		chk(dw_fault, 1, "dw 8");
		shift_valid = 1;
		shift_count = 3;
		@(negedge sys_clk);
		shift_count = 5;
		chk({shift_fault, block_base_pointer, block_word_count}, 33'h041550005, "shift");
		@(negedge sys_clk);
		shift_valid = 0;
		chk({shift_fault, block_base_pointer, block_word_count}, 33'h141550005, "refuse");
		acc_wr(1, 16'h1010);
		u_mem_model.cells[16'h1010] = 16'h4000;
		run_op(0, 6);
		chk({block_base_pointer, block_word_count}, 32'h40000005, "load base");
		stack_in = 16'hBEEF;
		stack_load = 1;
		op_pointer_in = 16'h0123;
		op_pointer_load = 1;
		@(negedge sys_clk);
		stack_load = 0;
		op_pointer_load = 0;
		chk(next_operation_pointer, 16'h0123, "next op");
		run_op(1, 5);
		chk(u_mem_model.last_wdata, 16'hBEEF, "stack store");
		run_op(1, 8);
		chk(u_mem_model.last_wdata, 16'h0005, "count store");
		restore_info = {16'h1234, 16'h0014};
		restore_valid = 1;
		@(negedge sys_clk);
		restore_valid = 0;
		chk({block_base_pointer, block_word_count}, 32'h12340014, "restore");
		entry_call = 1;
		@(negedge sys_clk);
		entry_call = 0;
		chk({block_base_pointer, block_word_count}, 32'h0, "entry");
	endtask
	initial
	begin
		repeat (4) @(negedge sys_clk);
		sys_rst = 0;
		t_acc_map();
		t_word();
		t_bytes();
		t_noop();
		t_acc1();
		t_block();
		close_out();
	end
	initial
	begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		close_out();
	end
endmodule
`default_nettype wire
